// *** core/default_result_sel.sv ***
// default result choice for conditions taken without a trap
`timescale 1ns/1ps
module default_result_sel (
    input wire logic [4:0] cause, // ieee cause bits of the operation
    input wire logic [1:0] round_select, // active rounding select
    input wire logic sign, // intermediate result sign
    output fp_exc_pkg::result_kind_t kind // result to deliver
);
    always_comb
    begin
        kind = fp_exc_pkg::res_computed;
        if (cause[fp_exc_pkg::BIT_INVALID])
            kind = fp_exc_pkg::res_qnan;
        else if (cause[fp_exc_pkg::BIT_DIVZERO])
            kind = fp_exc_pkg::res_inf;
        else if (cause[fp_exc_pkg::BIT_OVERFLOW])
        begin
            // overflow wins over its companion inexact
            case (fp_exc_pkg::round_select_t'(round_select))
                fp_exc_pkg::round_nearest_even:
                    kind = fp_exc_pkg::res_inf;
                fp_exc_pkg::round_toward_zero:
                    kind = fp_exc_pkg::res_max_finite;
                fp_exc_pkg::round_up_positive:
                    kind = sign ? fp_exc_pkg::res_max_finite : fp_exc_pkg::res_inf;
                fp_exc_pkg::round_down_negative:
                    kind = sign ? fp_exc_pkg::res_inf : fp_exc_pkg::res_max_finite;
                default:
                    kind = fp_exc_pkg::res_inf;
            endcase
        end
    end
endmodule // default_result_sel

// *** core/fp_exc_pkg.sv ***
// shared constants and types for the floating point exception unit
package fp_exc_pkg;
    // condition bit order inside every exception field
    localparam int unsigned EXC_W = 5;
    localparam int unsigned CAUSE_W = 6;
    localparam int unsigned BIT_INEXACT = 0;
    localparam int unsigned BIT_UNDERFLOW = 1;
    localparam int unsigned BIT_OVERFLOW = 2;
    localparam int unsigned BIT_DIVZERO = 3;
    localparam int unsigned BIT_INVALID = 4;
    localparam int unsigned BIT_UNIMPL = 5;
    // control register numbers on the control move port
    localparam logic [4:0] REG_EXCEPTIONS = 5'h1a;
    localparam logic [4:0] REG_ENABLES = 5'h1c;
    localparam logic [4:0] REG_CONTROL_STATUS = 5'h1f;
    // field positions
    localparam int unsigned CAUSE_LSB = 12;
    localparam int unsigned CAUSE_MSB = 17;
    localparam int unsigned EN_LSB = 7;
    localparam int unsigned EN_MSB = 11;
    localparam int unsigned FLAG_LSB = 2;
    localparam int unsigned FLAG_MSB = 6;
    localparam int unsigned RSEL_LSB = 0;
    localparam int unsigned RSEL_MSB = 1;
    localparam int unsigned ALIAS_FTZ_BIT = 2;
    localparam int unsigned CSR_FTZ_BIT = 24;
    // reset values: fields are undefined after reset, zero is used
    localparam logic [5:0] CAUSE_RST = 6'h00;
    localparam logic [4:0] EN_RST = 5'h00;
    localparam logic [4:0] FLAG_RST = 5'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        round_nearest_even,
        round_toward_zero,
        round_up_positive,
        round_down_negative
    } round_select_t;

    typedef enum logic [2:0] {
        op_add,
        op_sub,
        op_mul,
        op_div,
        op_sqrt,
        op_cvt_fix,
        op_cmp,
        op_move
    } op_kind_t;

    typedef enum logic [1:0] {
        res_computed,
        res_qnan,
        res_inf,
        res_max_finite
    } result_kind_t;
endpackage

// *** core/fp_exception_trap_logic.sv ***
// floating point exception, sticky flag and precise trap unit
`timescale 1ns/1ps
module fp_exception_trap_logic (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic ctl_wr, // control move write strobe
    input wire logic ctl_rd, // control move read strobe
    input wire logic [4:0] ctl_addr, // control register number
    input wire logic [31:0] ctl_wdata, // control move write data
    input wire logic op_valid, // operation issued this cycle
    input wire fp_exc_pkg::op_kind_t op_kind, // operation class
    input wire logic a_sign, // operand a sign
    input wire logic a_zero, // operand a is zero
    input wire logic a_inf, // operand a is infinity
    input wire logic a_snan, // operand a is signalling nan
    input wire logic a_qnan, // operand a is quiet nan
    input wire logic b_sign, // operand b sign
    input wire logic b_zero, // operand b is zero
    input wire logic b_inf, // operand b is infinity
    input wire logic b_snan, // operand b is signalling nan
    input wire logic b_qnan, // operand b is quiet nan
    input wire logic res_sign_in, // intermediate result sign
    input wire logic raw_overflow, // rounded result beyond largest finite
    input wire logic raw_tiny, // tiny nonzero result
    input wire logic raw_inexact, // rounded result not exact
    input wire logic raw_unimpl, // datapath cannot do this operation
    input wire logic cvt_overflow, // fixed conversion out of range
    input wire logic cmp_qnan_signals, // predicate signals on quiet nan
    output logic trap, // precise trap pulse
    output logic commit, // results may be written, pulse
    output fp_exc_pkg::result_kind_t res_kind, // result to deliver
    output logic res_sign, // sign of delivered result
    output logic [1:0] round_select, // active rounding select
    output logic flush_to_zero, // flush tiny values to zero
    output logic [31:0] ctl_rdata // control move read data
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [5:0] cause;
        logic [4:0] enables;
        logic [4:0] flags;
        logic ftz;
        logic [1:0] rsel;
        logic trap;
        logic commit;
        fp_exc_pkg::result_kind_t kind;
        logic sign;
        logic [31:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    operand_class_if oc ();
    logic invalid;
    logic [4:0] ieee;
    logic [4:0] ieee_raw;
    logic [5:0] cause_op;
    logic arith;
    logic divzero;
    logic unf;
    logic inx;
    logic op_traps;
    fp_exc_pkg::result_kind_t dflt_kind;

    assign oc.kind = op_kind;
    assign oc.a_sign = a_sign;
    assign oc.a_zero = a_zero;
    assign oc.a_inf = a_inf;
    assign oc.a_snan = a_snan;
    // compares look at either quiet nan operand
    assign oc.a_qnan = a_qnan | (op_kind == fp_exc_pkg::op_cmp && b_qnan);
    assign oc.b_zero = b_zero;
    assign oc.b_inf = b_inf;
    assign oc.b_snan = b_snan;
    assign oc.b_sign = b_sign;

    invalid_detect u_invalid (
        .oc(oc.chk),
        .cvt_overflow(cvt_overflow),
        .cmp_qnan_signals(cmp_qnan_signals),
        .invalid(invalid)
    );

    default_result_sel u_dflt (
        .cause(ieee),
        .round_select(s_reg.rsel),
        .sign(res_sign_in),
        .kind(dflt_kind)
    );

    ////////////////////////////////////////////////////////////////////////
    // condition assembly for the issuing operation
    always_comb
    begin
        arith = op_valid && (op_kind != fp_exc_pkg::op_move);
        divzero = (op_kind == fp_exc_pkg::op_div) && b_zero && !a_zero &&
            !a_inf && !a_snan && !a_qnan;
        // flushed tiny results always report underflow and inexact
        unf = raw_tiny && (raw_inexact || s_reg.ftz ||
            s_reg.enables[fp_exc_pkg::BIT_UNDERFLOW]);
        inx = raw_inexact || (raw_tiny && s_reg.ftz);
        ieee_raw = 5'h00;
        ieee_raw[fp_exc_pkg::BIT_INVALID] = invalid;
        ieee_raw[fp_exc_pkg::BIT_DIVZERO] = divzero;
        ieee_raw[fp_exc_pkg::BIT_OVERFLOW] = raw_overflow;
        ieee_raw[fp_exc_pkg::BIT_UNDERFLOW] = unf;
        ieee_raw[fp_exc_pkg::BIT_INEXACT] = inx || raw_overflow;
        // keep only the highest condition; inexact rides with over or under
        ieee = ieee_raw;
        if (ieee_raw[fp_exc_pkg::BIT_INVALID])
            ieee = 5'h00 | (5'h01 << fp_exc_pkg::BIT_INVALID);
        else if (ieee_raw[fp_exc_pkg::BIT_DIVZERO])
            ieee = 5'h00 | (5'h01 << fp_exc_pkg::BIT_DIVZERO);
        else if (ieee_raw[fp_exc_pkg::BIT_OVERFLOW])
            ieee[fp_exc_pkg::BIT_UNDERFLOW] = 1'b0;
        cause_op = {1'b0, ieee};
        if (raw_unimpl)
            cause_op = 6'h20;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: control move first, then the operation
    always_comb
    begin
        s_next = s_reg;
        s_next.trap = 1'b0;
        s_next.commit = 1'b0;
        op_traps = 1'b0;
        if (ctl_wr)
        begin
            case (ctl_addr)
                fp_exc_pkg::REG_CONTROL_STATUS:
                begin
                    s_next.cause = ctl_wdata[fp_exc_pkg::CAUSE_MSB:fp_exc_pkg::CAUSE_LSB];
                    s_next.enables = ctl_wdata[fp_exc_pkg::EN_MSB:fp_exc_pkg::EN_LSB];
                    s_next.flags = ctl_wdata[fp_exc_pkg::FLAG_MSB:fp_exc_pkg::FLAG_LSB];
                    s_next.ftz = ctl_wdata[fp_exc_pkg::CSR_FTZ_BIT];
                    s_next.rsel = ctl_wdata[fp_exc_pkg::RSEL_MSB:fp_exc_pkg::RSEL_LSB];
                end
                fp_exc_pkg::REG_EXCEPTIONS:
                begin
                    s_next.cause = ctl_wdata[fp_exc_pkg::CAUSE_MSB:fp_exc_pkg::CAUSE_LSB];
                    s_next.flags = ctl_wdata[fp_exc_pkg::FLAG_MSB:fp_exc_pkg::FLAG_LSB];
                end
                fp_exc_pkg::REG_ENABLES:
                begin
                    // reserved write bits are dropped
                    s_next.enables = ctl_wdata[fp_exc_pkg::EN_MSB:fp_exc_pkg::EN_LSB];
                    s_next.ftz = ctl_wdata[fp_exc_pkg::ALIAS_FTZ_BIT];
                    s_next.rsel = ctl_wdata[fp_exc_pkg::RSEL_MSB:fp_exc_pkg::RSEL_LSB];
                end
                default:
                    s_next.cause = s_next.cause;
            endcase
            // any move that leaves an enabled cause set traps at once
            s_next.trap = (|(s_next.cause[4:0] & s_next.enables)) | s_next.cause[5];
        end
        if (arith)
        begin
            s_next.cause = cause_op;
            op_traps = (|(cause_op[4:0] & s_next.enables)) | cause_op[5];
            s_next.trap = op_traps;
            if (!op_traps)
            begin
                // sticky flags only gain bits, and only on completion
                s_next.flags = s_next.flags | cause_op[4:0];
                s_next.commit = 1'b1;
                s_next.kind = dflt_kind;
                s_next.sign = (dflt_kind == fp_exc_pkg::res_qnan) ? 1'b0 :
                    (divzero ? (a_sign ^ b_sign) : res_sign_in);
            end
            else
                s_next.commit = 1'b0;
        end
        else if (op_valid)
        begin
            // moves raise nothing and leave the cause field alone
            s_next.commit = 1'b1;
            s_next.kind = fp_exc_pkg::res_computed;
            s_next.sign = res_sign_in;
        end
        s_next.rdata = fp_exc_pkg::RDATA_RST;
        if (ctl_rd)
        begin
            case (ctl_addr)
                fp_exc_pkg::REG_CONTROL_STATUS:
                begin
                    s_next.rdata[fp_exc_pkg::CAUSE_MSB:fp_exc_pkg::CAUSE_LSB] =
                        s_reg.cause;
                    s_next.rdata[fp_exc_pkg::EN_MSB:fp_exc_pkg::EN_LSB] = s_reg.enables;
                    s_next.rdata[fp_exc_pkg::FLAG_MSB:fp_exc_pkg::FLAG_LSB] = s_reg.flags;
                    s_next.rdata[fp_exc_pkg::CSR_FTZ_BIT] = s_reg.ftz;
                    s_next.rdata[fp_exc_pkg::RSEL_MSB:fp_exc_pkg::RSEL_LSB] = s_reg.rsel;
                end
                fp_exc_pkg::REG_EXCEPTIONS:
                begin
                    s_next.rdata[fp_exc_pkg::CAUSE_MSB:fp_exc_pkg::CAUSE_LSB] =
                        s_reg.cause;
                    s_next.rdata[fp_exc_pkg::FLAG_MSB:fp_exc_pkg::FLAG_LSB] = s_reg.flags;
                end
                fp_exc_pkg::REG_ENABLES:
                begin
                    // bits 31:12 and 6:3 stay zero
                    s_next.rdata[fp_exc_pkg::EN_MSB:fp_exc_pkg::EN_LSB] =
                        s_reg.enables;
                    s_next.rdata[fp_exc_pkg::ALIAS_FTZ_BIT] = s_reg.ftz;
                    s_next.rdata[fp_exc_pkg::RSEL_MSB:fp_exc_pkg::RSEL_LSB] = s_reg.rsel;
                end
                default:
                    s_next.rdata = fp_exc_pkg::RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '{cause: fp_exc_pkg::CAUSE_RST, enables: fp_exc_pkg::EN_RST,
                flags: fp_exc_pkg::FLAG_RST, ftz: 1'b0, rsel: 2'h0, trap: 1'b0,
                commit: 1'b0, kind: fp_exc_pkg::res_computed, sign: 1'b0,
                rdata: fp_exc_pkg::RDATA_RST};
        end
        else if (clk_en)
        begin
            s_reg <= s_next;
        end
    end

    assign trap = s_reg.trap;
    assign commit = s_reg.commit;
    assign res_kind = s_reg.kind;
    assign res_sign = s_reg.sign;
    assign round_select = s_reg.rsel;
    assign flush_to_zero = s_reg.ftz;
    assign ctl_rdata = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic op_q;
    logic ev_q;
    logic rd_en_q;
    logic op_nw_q;
    logic mv_q;
    logic [1:0] rsel_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_q <= 1'b0;
            ev_q <= 1'b0;
            rd_en_q <= 1'b0;
            op_nw_q <= 1'b0;
            mv_q <= 1'b0;
            rsel_q <= 2'h0;
        end
        else
        begin
            op_q <= clk_en && arith;
            ev_q <= clk_en && (arith || ctl_wr);
            rd_en_q <= clk_en && ctl_rd && (ctl_addr == fp_exc_pkg::REG_ENABLES);
            // a same-cycle move may rewrite flags or cause, so skip those
            op_nw_q <= clk_en && arith && !ctl_wr;
            mv_q <= clk_en && op_valid && !arith && !ctl_wr;
            // rounding select that the operation really used
            rsel_q <= s_reg.rsel;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_trap_on_enabled: assert property (
        ev_q |-> trap == ((|(s_reg.cause[4:0] & s_reg.enables)) || s_reg.cause[5]))
        else $error("trap does not match enabled cause");
    a_unimpl_traps: assert property (ev_q && s_reg.cause[5] |-> trap)
        else $error("unimplemented cause without trap");
    a_trap_no_commit: assert property (!(trap && commit))
        else $error("trapping op committed");
    a_op_answer: assert property (op_q |-> trap != commit)
        else $error("operation gave neither or both of trap and commit");
    a_flags_only_grow: assert property (
        clk_en && !ctl_wr |=> (($past(s_reg.flags) & ~s_reg.flags) == 5'h00))
        else $error("sticky flag cleared by operation");
    a_trap_keeps_flags: assert property (
        op_nw_q && trap |-> s_reg.flags == $past(s_reg.flags))
        else $error("trapping op changed sticky flags");
    a_sticky_set: assert property (
        op_q && commit |-> (s_reg.cause[4:0] & ~s_reg.flags) == 5'h00)
        else $error("completed condition missing from sticky flags");
    a_move_keeps_cause: assert property (mv_q |-> s_reg.cause == $past(s_reg.cause))
        else $error("register move changed the cause field");
    a_alias_reserved: assert property (
        rd_en_q |-> ctl_rdata[31:12] == 20'h00000 && ctl_rdata[6:3] == 4'h0)
        else $error("enables alias reserved bits not zero");
    a_one_condition: assert property (op_q |-> $countones(s_reg.cause[4:1]) <= 1)
        else $error("more than one main condition raised");
    a_invalid_qnan: assert property (
        op_q && commit && s_reg.cause[4] |-> res_kind == fp_exc_pkg::res_qnan && !res_sign)
        else $error("untrapped invalid not quiet nan");
    a_divzero_inf: assert property (
        op_q && commit && s_reg.cause[3] |-> res_kind == fp_exc_pkg::res_inf)
        else $error("untrapped divide by zero not infinity");
    a_ovf_nearest: assert property (
        op_q && commit && s_reg.cause[2] && s_reg.cause[4:3] == 2'h0 && rsel_q == 2'h0
        |-> res_kind == fp_exc_pkg::res_inf)
        else $error("nearest overflow not infinity");
    a_ovf_zero: assert property (
        op_q && commit && s_reg.cause[2] && s_reg.cause[4:3] == 2'h0 && rsel_q == 2'h1
        |-> res_kind == fp_exc_pkg::res_max_finite)
        else $error("toward zero overflow not largest finite");
    a_ovf_directed: assert property (
        op_q && commit && s_reg.cause[2] && s_reg.cause[4:3] == 2'h0 && rsel_q[1]
        |-> res_kind == ((res_sign ^ rsel_q[0]) ? fp_exc_pkg::res_max_finite :
            fp_exc_pkg::res_inf))
        else $error("directed overflow result wrong for sign");

    c_trap_op: cover property (op_q && trap);
    c_trap_move: cover property (!op_q && ev_q && trap);
    c_default_inf: cover property (commit && res_kind == fp_exc_pkg::res_inf);
    c_default_qnan: cover property (commit && res_kind == fp_exc_pkg::res_qnan);
    c_unimpl_trap: cover property (ev_q && trap && s_reg.cause[5]);
endmodule // fp_exception_trap_logic

// *** core/invalid_detect.sv ***
// invalid operation detection from operand classes
`timescale 1ns/1ps
module invalid_detect (
    operand_class_if.chk oc, // operand classes
    input wire logic cvt_overflow, // converter saw out of range value
    input wire logic cmp_qnan_signals, // compare predicate signals on qnan
    output logic invalid // invalid operation condition
);
    logic arith;
    logic inf_sub;
    always_comb
    begin
        arith = (oc.kind != fp_exc_pkg::op_move);
        inf_sub = oc.a_inf && oc.b_inf &&
            ((oc.kind == fp_exc_pkg::op_add && (oc.a_sign != oc.b_sign)) ||
             (oc.kind == fp_exc_pkg::op_sub && (oc.a_sign == oc.b_sign)));
        invalid = 1'b0;
        if (arith && (oc.a_snan || oc.b_snan))
            invalid = 1'b1;
        case (oc.kind)
            fp_exc_pkg::op_add, fp_exc_pkg::op_sub:
                invalid = invalid | inf_sub;
            fp_exc_pkg::op_mul:
                invalid = invalid | (oc.a_zero && oc.b_inf) | (oc.a_inf && oc.b_zero);
            fp_exc_pkg::op_div:
                invalid = invalid | (oc.a_zero && oc.b_zero) | (oc.a_inf && oc.b_inf);
            fp_exc_pkg::op_sqrt:
                // minus zero is a legal root operand
                invalid = invalid | (oc.a_sign && !oc.a_zero && !oc.a_qnan);
            fp_exc_pkg::op_cvt_fix:
                invalid = invalid | cvt_overflow | oc.a_inf | oc.a_qnan;
            fp_exc_pkg::op_cmp:
                invalid = invalid | (cmp_qnan_signals && oc.a_qnan);
            default:
                invalid = invalid;
        endcase
    end
endmodule // invalid_detect

// *** core/operand_class_if.sv ***
// operand classification carried from the top to the invalid detector
`timescale 1ns/1ps
interface operand_class_if;
    fp_exc_pkg::op_kind_t kind;
    logic a_sign;
    logic a_zero;
    logic a_inf;
    logic a_snan;
    logic a_qnan;
    logic b_zero;
    logic b_inf;
    logic b_snan;
    logic b_sign;
    modport src (output kind, a_sign, a_zero, a_inf, a_snan, a_qnan,
        b_zero, b_inf, b_snan, b_sign);
    modport chk (input kind, a_sign, a_zero, a_inf, a_snan, a_qnan,
        b_zero, b_inf, b_snan, b_sign);
endinterface // operand_class_if

// *** tb/pipe_model.sv ***
// pipeline model issuing one floating point operation per call
`timescale 1ns/1ps
module pipe_model (
    input wire logic clk, // core clock
    output logic op_valid, // operation issue strobe
    output logic [19:0] ops // kind, operand classes, datapath flags
);
    initial
    begin
        op_valid = 1'b0;
        ops = 20'h00000;
    end
    // released lines carry the inverse so stale values never look valid
    task automatic issue(input logic [19:0] v);
        @(negedge clk);
        op_valid = 1'b1;
        ops = v;
        @(negedge clk);
        op_valid = 1'b0;
        ops = ~v;
    endtask
endmodule // pipe_model

// *** tb/tb.sv ***
// self-checking bench for the floating point exception unit
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic ctl_wr = 1'b0;
    logic ctl_rd = 1'b0;
    logic [4:0] ctl_addr = 5'h00;
    logic [31:0] ctl_wdata = 32'h0000_0000;
    logic op_valid, trap, commit, res_sign, flush_to_zero;
    logic [19:0] ops;
    fp_exc_pkg::result_kind_t res_kind;
    logic [1:0] round_select;
    logic [31:0] ctl_rdata;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] seed = 8'h44;
    // {invalid expected, operation}
    logic [20:0] tbl [10] = '{21'h104a00, 21'h124200, 21'h148200, 21'h168400, 21'h164200,
        21'h190000, 21'h1a0002, 21'h1c1001, 21'h102000, 21'h098000};

    pipe_model pm (.clk(clk), .op_valid(op_valid), .ops(ops));
    fp_exception_trap_logic DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .ctl_wr(ctl_wr),
        .ctl_rd(ctl_rd), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .op_valid(op_valid),
        .op_kind(fp_exc_pkg::op_kind_t'(ops[19:17])), .a_sign(ops[16]), .a_zero(ops[15]),
        .a_inf(ops[14]), .a_snan(ops[13]), .a_qnan(ops[12]), .b_sign(ops[11]), .b_zero(ops[10]),
        .b_inf(ops[9]), .b_snan(ops[8]), .b_qnan(ops[7]), .res_sign_in(ops[6]),
        .raw_overflow(ops[5]), .raw_tiny(ops[4]), .raw_inexact(ops[3]), .raw_unimpl(ops[2]),
        .cvt_overflow(ops[1]), .cmp_qnan_signals(ops[0]), .trap(trap), .commit(commit),
        .res_kind(res_kind), .res_sign(res_sign), .round_select(round_select),
        .flush_to_zero(flush_to_zero), .ctl_rdata(ctl_rdata));

    always #20 clk = ~clk;

    // hang guard, far above the roughly 160 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [1:0] ovf_kind(input logic [1:0] r, input logic s);
        return (r == 2'h0 || (r == 2'h2 && !s) || (r == 2'h3 && s)) ?
            fp_exc_pkg::res_inf : fp_exc_pkg::res_max_finite;
    endfunction
    function automatic logic [31:0] csr(input logic f, input logic [4:0] en, input logic [1:0] r);
        return {7'h0, f, 12'h0, en, 5'h0, r};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(negedge clk);
        ctl_wr = 1'b1;
        ctl_addr = a;
        ctl_wdata = d;
        @(negedge clk);
        ctl_wr = 1'b0;
        ctl_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string name);
        @(negedge clk);
        ctl_rd = 1'b1;
        ctl_addr = a;
        @(negedge clk);
        ctl_rd = 1'b0;
        check(name, ctl_rdata, exp);
    endtask
    task automatic op(input logic [19:0] v, input logic tr, input logic [1:0] k, input logic s);
        pm.issue(v);
        check("op result", {27'h0, trap, commit, tr ? 3'h0 : {res_kind, res_sign}},
            {27'h0, tr, ~tr, tr ? 3'h0 : {k, s}});
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        logic [1:0] r;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        rd(fp_exc_pkg::REG_CONTROL_STATUS, 32'h0, "csr reset");
        wr(fp_exc_pkg::REG_ENABLES, 32'h0000_0f87);
        rd(fp_exc_pkg::REG_ENABLES, 32'h0000_0f87, "alias");
        rd(fp_exc_pkg::REG_CONTROL_STATUS, csr(1'b1, 5'h1f, 2'h3), "csr view");
        check("ctl out", {29'h0, flush_to_zero, round_select}, 32'h7);
        wr(fp_exc_pkg::REG_CONTROL_STATUS, csr(1'b0, 5'h00, 2'h2));
        rd(fp_exc_pkg::REG_ENABLES, 32'h2, "alias back");
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            r = (i < 4) ? i[1:0] : seed[1:0];
            wr(fp_exc_pkg::REG_ENABLES, {30'h0, r});
            op({13'h0400, seed[2], 6'h28}, 1'b0, ovf_kind(r, seed[2]),
                seed[2]);
            rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h5014, "ovf cause");
        end
        op(20'he2000, 1'b0, fp_exc_pkg::res_computed, 1'b0);
        rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h5014, "move keeps");
        wr(fp_exc_pkg::REG_ENABLES, 32'h0);
        foreach (tbl[i])
        begin
            op(tbl[i][19:0], 1'b0, tbl[i][20] ? fp_exc_pkg::res_qnan : fp_exc_pkg::res_computed,
                1'b0);
            rd(fp_exc_pkg::REG_EXCEPTIONS, {15'h0, tbl[i][20], 16'h0054}, "inv cause");
        end
        wr(fp_exc_pkg::REG_ENABLES, 32'h400);
        op(20'h60400, 1'b1, 2'h0, 1'b0);
        rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h8054, "trap flags");
        wr(fp_exc_pkg::REG_EXCEPTIONS, 32'h54);
        check("no retrap", {31'h0, trap}, 32'h0);
        wr(fp_exc_pkg::REG_EXCEPTIONS, 32'h8054);
        check("write trap", {31'h0, trap}, 32'h1);
        wr(fp_exc_pkg::REG_EXCEPTIONS, 32'h54);
        wr(fp_exc_pkg::REG_ENABLES, 32'h0);
        op(20'h00004, 1'b1, 2'h0, 1'b0);
        rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h20054, "unimpl");
        wr(fp_exc_pkg::REG_EXCEPTIONS, 32'h0);
        op(20'h70400, 1'b0, fp_exc_pkg::res_inf, 1'b1);
        rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h8020, "divzero");
        // a move while the enable is low must leave every field alone
        @(negedge clk);
        clk_en = 1'b0;
        wr(fp_exc_pkg::REG_EXCEPTIONS, 32'h0);
        @(negedge clk);
        clk_en = 1'b1;
        rd(fp_exc_pkg::REG_EXCEPTIONS, 32'h8020, "frozen");
        conclude();
    end
endmodule // tb
